// [hw/vcf_capture_buffer.sv]
// video capture data buffer: three segments, status-coded words, AHB-Lite control
// assumes pixel stream and reader both run on hclk; one bus slave, zero wait states
// Overview of operation
// - three segments of 36-bit words, depths 70, 35 and 35.
// - word holds pixel dword in bits 31:0, status code in 35:32.
// - pixels are stored only while valid pixels are inside a field.
// - code 0110 announces packed data, 1110 announces planar data.
// - 0010 marks first dword of a line, 0000 any other word.
// - last dword of a line carries 0001, 1101, 1001 or 0101 by byte count.
// - 0100 ends even field on field falling edge, 1100 odd on rising.
// - mode marker at field start, format change and asynchronous capture enable.
// - every capture sequence starts with a mode marker before pixel words.
// - markers go twice into luma, once into each chroma segment.
// - field end code is written at the end of each captured field.
// - blanking interval data is stored only when its capture is enabled.
// - full when count reaches 68 for luma, 34 for chroma.
// - almost full at 64 for luma, 32 for chroma.
// - planar segments run independently; packed mode spreads words over the three segments, 140 words in all.
// - packed and planar words may sit in the buffer together.
// - all three segment heads are presented and popped in parallel.
// - write and read ports work at the same time.
// - never the same segment twice in a row; packed order luma, blue, luma, red.
// - at most one word per segment per cycle, all three at once.
//
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
`include "vcf_regs.svh"

module vcf_capture_buffer import vcf_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire vcf_pixel_t pixel_dword_in,
    input wire logic field_active,
    input wire logic field_odd,
    input wire logic vbi_active,
    output logic pix_ready,
    input wire logic [2:0] seg_pop,
    output vcf_word_t [2:0] seg_head,
    output logic [2:0] seg_nonempty,
    output logic [2:0] segment_full_flag,
    output logic [2:0] segment_almost_full_flag
);

    vcf_state_t s;
    vcf_state_t n;
    vcf_word_t mem [0:139];
    logic we;
    logic [1:0] wseg;
    vcf_word_t wword;
    logic [7:0] waddr;
    logic [2:0] push;
    logic [2:0] pop;
    logic [7:0] raddr;
    logic conflict;
    logic accept;
    logic [1:0] dseg;

    function automatic logic [6:0] seg_size(input logic [1:0] k);
        return (k == 2'd0) ? `VCF_LUMA_SIZE : `VCF_CHROMA_SIZE;
    endfunction

    function automatic logic [7:0] seg_base(input logic [1:0] k);
        if (k == 2'd0) begin
            return `VCF_LUMA_BASE;
        end else if (k == 2'd1) begin
            return `VCF_BLUE_BASE;
        end
        return `VCF_RED_BASE;
    endfunction

    function automatic logic [6:0] bump(input logic [6:0] p, input logic [1:0] k);
        return (p == seg_size(k) - 7'd1) ? 7'd0 : p + 7'd1;
    endfunction

    function automatic logic [3:0] last_code(input logic [1:0] nb);
        case (nb)
            2'd3: return `VCF_CODE_LAST4;
            2'd2: return `VCF_CODE_LAST3;
            2'd1: return `VCF_CODE_LAST2;
            default: return `VCF_CODE_LAST1;
        endcase
    endfunction

    // flags and heads per segment
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_seg
            assign segment_full_flag[g] = s.cnt[g] >= ((g == 0) ? `VCF_LUMA_FULL : `VCF_CHROMA_FULL);
            assign segment_almost_full_flag[g] =
                s.cnt[g] >= ((g == 0) ? `VCF_LUMA_AFULL : `VCF_CHROMA_AFULL);
            assign seg_nonempty[g] = s.cnt[g] != 7'd0;
            assign seg_head[g] = s.head[g];
        end
    endgenerate

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s.hrdata;

    // packed mode spreads words luma, blue, luma, red
    assign dseg = s.planar ? pixel_dword_in.seg
        : ((s.pk_phase == 2'd1) ? 2'd1 : ((s.pk_phase == 2'd3) ? 2'd2 : 2'd0));
    assign conflict = s.wrote_last && (s.last_seg == dseg);
    assign pix_ready = (s.seq == SEQ_IDLE) && !s.pend_mark && !s.pend_end && !conflict;
    assign accept = pixel_dword_in.valid && pix_ready && s.cap_en && s.cap_seen && field_active
        && (!vbi_active || s.vbi_en);

    always_comb begin
        n = s;
        we = 1'b0;
        wseg = 2'd0;
        wword = '0;
        push = 3'b000;
        pop = 3'b000;
        raddr = 8'h00;
        // write sequencer
        case (s.seq)
            SEQ_IDLE: begin
                if (s.pend_end && !(s.wrote_last && s.last_seg == 2'd0)) begin
                    n.seq = SEQ_END;
                end else if (s.pend_mark && !s.pend_end && !(s.wrote_last && s.last_seg == 2'd0)) begin
                    n.seq = SEQ_M1;
                end
                if (accept) begin
                    we = 1'b1;
                    wseg = dseg;
                    wword.data = pixel_dword_in.dword;
                    if (pixel_dword_in.line_last) begin
                        wword.code = last_code(pixel_dword_in.last_bytes);
                    end else if (pixel_dword_in.line_first) begin
                        wword.code = `VCF_CODE_FIRST;
                    end else begin
                        wword.code = `VCF_CODE_PLAIN;
                    end
                    if (!s.planar) begin
                        n.pk_phase = s.pk_phase + 2'd1;
                    end
                end
            end
            SEQ_END: begin
                we = 1'b1;
                wword.code = s.end_odd ? `VCF_CODE_ODD_END : `VCF_CODE_EVEN_END;
                n.pend_end = 1'b0;
                n.cap_seen = 1'b0;
                n.seq = SEQ_IDLE;
            end
            SEQ_M1: begin
                we = 1'b1;
                n.planar = s.ctrl_planar_q;
                n.seq = SEQ_M2;
            end
            SEQ_M2: begin
                we = 1'b1;
                wseg = 2'd1;
                n.seq = SEQ_M3;
            end
            SEQ_M3: begin
                we = 1'b1;
                n.seq = SEQ_M4;
            end
            SEQ_M4: begin
                we = 1'b1;
                wseg = 2'd2;
                n.pend_mark = 1'b0;
                n.cap_seen = 1'b1;
                n.pk_phase = 2'd0;
                n.seq = SEQ_IDLE;
            end
            default: begin
                n.seq = SEQ_IDLE;
            end
        endcase
        if (s.seq != SEQ_IDLE && s.seq != SEQ_END) begin
            wword.code = n.planar ? `VCF_CODE_PLANAR : `VCF_CODE_PACKED;
        end
        n.wrote_last = we;
        n.last_seg = wseg;
        // events, set after clear so nothing is lost
        n.field_prev = field_odd;
        if (field_odd != s.field_prev && s.cap_en) begin
            if (s.cap_seen) begin
                n.pend_end = 1'b1;
                n.end_odd = field_odd;
            end
            n.pend_mark = 1'b1;
        end
        // bus data phase
        if (s.ap_valid && s.ap_write && s.ap_addr == `VCF_CTRL_OFS) begin
            n.cap_en = hwdata[`VCF_CTRL_CAP_BIT];
            n.vbi_en = hwdata[`VCF_CTRL_VBI_BIT];
            n.ctrl_planar_q = hwdata[`VCF_CTRL_PLANAR_BIT];
            if (hwdata[`VCF_CTRL_CAP_BIT] && !s.cap_en) begin
                n.pend_mark = 1'b1;
            end
            if (s.cap_en && hwdata[`VCF_CTRL_PLANAR_BIT] != s.ctrl_planar_q) begin
                n.pend_mark = 1'b1;
            end
        end
        // segment pointers, write and read in the same cycle
        waddr = seg_base(wseg) + {1'b0, s.wp[wseg]};
        for (int k = 0; k < 3; k++) begin
            push[k] = we && (wseg == 2'(k));
            pop[k] = seg_pop[k] && (s.cnt[k] != 7'd0);
            if (push[k]) begin
                n.wp[k] = bump(s.wp[k], 2'(k));
            end
            if (pop[k] || (push[k] && s.cnt[k] == seg_size(2'(k)))) begin
                n.rp[k] = bump(s.rp[k], 2'(k));
            end
            if (push[k] && !pop[k] && s.cnt[k] != seg_size(2'(k))) begin
                n.cnt[k] = s.cnt[k] + 7'd1;
            end else if (pop[k] && !push[k]) begin
                n.cnt[k] = s.cnt[k] - 7'd1;
            end
            raddr = seg_base(2'(k)) + {1'b0, n.rp[k]};
            n.head[k] = (push[k] && raddr == waddr) ? wword : mem[raddr];
        end
        // bus address phase
        n.ap_valid = hsel && hready && htrans[1];
        n.ap_write = hwrite;
        n.ap_addr = haddr[7:0];
        if (hsel && hready && htrans[1] && !hwrite) begin
            if (haddr[7:0] == `VCF_CTRL_OFS) begin
                n.hrdata = {29'h0, s.ctrl_planar_q, s.vbi_en, s.cap_en};
            end else if (haddr[7:0] == `VCF_COUNT_OFS) begin
                n.hrdata = {9'h0, s.cnt[2], 1'b0, s.cnt[1], 1'b0, s.cnt[0]};
            end else if (haddr[7:0] == `VCF_FLAG_OFS) begin
                n.hrdata = {23'h0, s.seq != SEQ_IDLE, 1'b0, segment_almost_full_flag, 1'b0, segment_full_flag};
            end else begin
                n.hrdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.seq <= SEQ_IDLE;
        end else begin
            s <= n;
        end
    end

    // storage, one write port shared by the three segments
    always_ff @(posedge hclk) begin
        if (we) begin
            mem[waddr] <= wword;
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_marker_walk;
        we && wseg == 2'd0 ##1 we && wseg == 2'd1 ##1 we && wseg == 2'd0 ##1 we && wseg == 2'd2;
    endsequence

    a_seg_depth: assert property (s.cnt[0] <= `VCF_LUMA_SIZE && s.cnt[1] <= `VCF_CHROMA_SIZE)
        else $error("segment count beyond depth");
    a_word_layout: assert property (accept |-> we && wword.data == pixel_dword_in.dword)
        else $error("pixel dword not stored in low bits");
    a_write_gate: assert property (we && s.seq == SEQ_IDLE |-> field_active && s.cap_en)
        else $error("pixel stored outside a field");
    a_marker_code: assert property ($rose(s.seq == SEQ_M1)
        |=> wword.code == (n.planar ? `VCF_CODE_PLANAR : `VCF_CODE_PACKED))
        else $error("wrong mode marker code");
    a_first_code: assert property (accept && pixel_dword_in.line_first && !pixel_dword_in.line_last
        |-> wword.code == `VCF_CODE_FIRST)
        else $error("line first word code wrong");
    a_last_code: assert property (accept && pixel_dword_in.line_last && pixel_dword_in.last_bytes == 2'd2
        |-> wword.code == `VCF_CODE_LAST3)
        else $error("three byte line end code wrong");
    a_marker_split: assert property (s.seq == SEQ_IDLE ##1 s.seq == SEQ_M1 |-> s_marker_walk ##1 s.seq == SEQ_IDLE)
        else $error("mode marker not spread over segments");
    a_luma_full: assert property (s.cnt[0] == `VCF_LUMA_FULL |-> segment_full_flag[0] ##0 $past(s.cnt[0]) != `VCF_LUMA_FULL
        || segment_full_flag[0])
        else $error("luma full flag wrong at threshold");
    a_chroma_full: assert property (s.cnt[1] == 7'd33 |-> !segment_full_flag[1] && segment_almost_full_flag[1])
        else $error("chroma full flag early");
    a_afull_edge: assert property (s.cnt[2] == 7'd31 |-> !segment_almost_full_flag[2])
        else $error("almost full flag early");
    a_no_repeat: assert property (we |=> !we || wseg != $past(wseg))
        else $error("same segment written twice in a row");
    a_count_step: assert property (pop[0] && !push[0] |=> s.cnt[0] == $past(s.cnt[0]) - 7'd1)
        else $error("pop did not lower count by one");

endmodule

// [include/vcf_regs.svh]
// constants for the video capture data buffer
// assumes a 32-bit AHB-Lite register window decoded on haddr[7:0]
`ifndef VCF_REGS_SVH
`define VCF_REGS_SVH

// register byte offsets
`define VCF_CTRL_OFS 8'h00
`define VCF_COUNT_OFS 8'h04
`define VCF_FLAG_OFS 8'h08

// control bit positions
`define VCF_CTRL_CAP_BIT 0
`define VCF_CTRL_VBI_BIT 1
`define VCF_CTRL_PLANAR_BIT 2

// segment geometry
`define VCF_LUMA_SIZE 7'd70
`define VCF_CHROMA_SIZE 7'd35
`define VCF_LUMA_BASE 8'h00
`define VCF_BLUE_BASE 8'h46
`define VCF_RED_BASE 8'h69
`define VCF_MERGED_SIZE 8'h8C
`define VCF_LUMA_FULL 7'd68
`define VCF_CHROMA_FULL 7'd34
`define VCF_LUMA_AFULL 7'd64
`define VCF_CHROMA_AFULL 7'd32

// status codes
`define VCF_CODE_PACKED 4'h6
`define VCF_CODE_PLANAR 4'hE
`define VCF_CODE_FIRST 4'h2
`define VCF_CODE_PLAIN 4'h0
`define VCF_CODE_LAST4 4'h1
`define VCF_CODE_LAST3 4'hD
`define VCF_CODE_LAST2 4'h9
`define VCF_CODE_LAST1 4'h5
`define VCF_CODE_EVEN_END 4'h4
`define VCF_CODE_ODD_END 4'hC

`endif

// [include/vcf_pkg.sv]
// types shared by the video capture data buffer
// assumes vcf_regs.svh is on the include path
package vcf_pkg;

    typedef enum logic [5:0] {
        SEQ_IDLE = 6'h01,
        SEQ_M1 = 6'h02,
        SEQ_M2 = 6'h04,
        SEQ_M3 = 6'h08,
        SEQ_M4 = 6'h10,
        SEQ_END = 6'h20
    } vcf_seq_t;

    typedef struct packed {
        logic [3:0] code;
        logic [31:0] data;
    } vcf_word_t;

    typedef struct packed {
        logic valid;
        logic [1:0] seg;
        logic line_first;
        logic line_last;
        logic [1:0] last_bytes;
        logic [31:0] dword;
    } vcf_pixel_t;

    typedef struct packed {
        vcf_seq_t seq;
        logic cap_en;
        logic vbi_en;
        logic planar;
        logic ctrl_planar_q;
        logic field_prev;
        logic cap_seen;
        logic pend_mark;
        logic pend_end;
        logic end_odd;
        logic wrote_last;
        logic [1:0] last_seg;
        logic [1:0] pk_phase;
        logic [2:0][6:0] wp;
        logic [2:0][6:0] rp;
        logic [2:0][6:0] cnt;
        vcf_word_t [2:0] head;
        logic ap_valid;
        logic ap_write;
        logic [7:0] ap_addr;
        logic [31:0] hrdata;
    } vcf_state_t;

endpackage

// [dv/vcf_dma_reader.sv]
// reader model: pops the three segment heads for the dma side
// assumes seg_pop is sampled by the buffer on the same hclk edge
`timescale 1ns/100ps

module vcf_dma_reader import vcf_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic en,
    input wire logic slow,
    input wire logic [2:0] nonempty,
    input wire logic [2:0] full,
    output logic [2:0] seg_pop
);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seg_pop <= 3'h0;
        end else if (en) begin
            seg_pop <= ((slow ? ~seg_pop : 3'h7) | full) & nonempty;
        end else begin
            seg_pop <= 3'h0;
        end
    end
endmodule

// [dv/tb_video_capture_data_fifo.sv]
// bench for the capture buffer: bus tasks, pixel driver, word monitor
// assumes a zero-wait bus slave and the reader model beside it
`timescale 1ns/100ps
`include "vcf_regs.svh"

module tb_video_capture_data_fifo import vcf_pkg::*;;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ren = 1'b0, rslow = 1'b0;
    logic fact = 1'b1, fodd = 1'b0, vbi = 1'b0, planar = 1'b0, hready, hresp, prdy;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
    logic [1:0] htrans = 2'h0, ph = 2'h0;
    logic [2:0] hsize = 3'h2, pop, ne, full, af;
    vcf_pixel_t pix = '0;
    vcf_word_t [2:0] head;
    logic [35:0] q[3][$];
    logic [3:0] lastc[4] = '{`VCF_CODE_LAST1, `VCF_CODE_LAST2, `VCF_CODE_LAST3, `VCF_CODE_LAST4};
    int n_fail = 0, samples_checked = 0, npx = 0;

    always #2.5 hclk = ~hclk;

    vcf_capture_buffer vcf_capture_buffer_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hresp(hresp), .hrdata(hrdata), .pixel_dword_in(pix), .field_active(fact), .field_odd(fodd),
        .vbi_active(vbi), .pix_ready(prdy), .seg_pop(pop), .seg_head(head), .seg_nonempty(ne),
        .segment_full_flag(full), .segment_almost_full_flag(af));

    vcf_dma_reader vcf_dma_reader_inst (.hclk(hclk), .hresetn(hresetn), .en(ren), .slow(rslow),
        .nonempty(ne), .full(full), .seg_pop(pop));

    task automatic check(input logic [35:0] got, input logic [35:0] want);
        samples_checked++;
        if (got !== want) begin
            n_fail++;
            $display("[FAIL] %0t got %h want %h", $time, got, want);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    function automatic logic [35:0] msk(input vcf_word_t w);
        if (w.code inside {`VCF_CODE_PACKED, `VCF_CODE_PLANAR, `VCF_CODE_EVEN_END, `VCF_CODE_ODD_END}) begin
            return {w.code, 32'h0};
        end
        return w;
    endfunction

    always @(posedge hclk) begin
        for (int k = 0; k < 3; k++) begin
            if (pop[k] & ne[k]) begin
                if (q[k].size() == 0) check(36'h1, 36'h0);
                else check(msk(head[k]), q[k].pop_front());
            end
        end
    end

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rdv = hrdata;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] want);
        bus(1'b0, a, 32'h0);
        check({4'h0, rdv}, {4'h0, want});
    endtask

    task automatic wt(input int n);
        pix.valid <= 1'b0;
        repeat (n) @(posedge hclk);
    endtask

    task automatic ctrl(input logic [31:0] v);
        wt(1);
        bus(1'b1, `VCF_CTRL_OFS, v);
        planar = v[`VCF_CTRL_PLANAR_BIT];
        wt(8);
    endtask

    // markers land twice in luma, once in each chroma segment
    task automatic mark(input logic [3:0] c);
        q[0].push_back({c, 32'h0});
        q[0].push_back({c, 32'h0});
        q[1].push_back({c, 32'h0});
        q[2].push_back({c, 32'h0});
        ph = 2'h0;
    endtask

    task automatic px(input logic [1:0] s, input logic f, input logic l, input logic [1:0] lb, input logic keep);
        logic [31:0] d;
        logic [1:0] g;
        d = {16'hC0DE, npx[15:0]};
        npx++;
        pix <= '{1'b1, s, f, l, lb, d};
        do @(negedge hclk); while (prdy !== 1'b1);
        @(posedge hclk);
        if (keep) begin
            g = planar ? s : (ph[0] ? {ph[1], ~ph[1]} : 2'h0);
            q[g].push_back({l ? lastc[lb] : (f ? `VCF_CODE_FIRST : `VCF_CODE_PLAIN), d});
            ph = planar ? 2'h0 : ph + 2'h1;
        end
    endtask

    task automatic rst();
        ren <= 1'b0;
        pix <= '0;
        hresetn <= 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        for (int k = 0; k < 3; k++) q[k].delete();
        ph = 2'h0;
    endtask

    task automatic drain(input logic sl);
        wt(1);
        ren <= 1'b1;
        rslow <= sl;
        for (int i = 0; i < 600 && (ne !== 3'h0 || q[0].size() + q[1].size() + q[2].size() > 0); i++) begin
            @(posedge hclk);
        end
        check(36'(q[0].size() + q[1].size() + q[2].size()), 36'h0);
        ren <= 1'b0;
    endtask

    task automatic t_regs();
        rchk(`VCF_CTRL_OFS, 32'h0);
        rchk(`VCF_COUNT_OFS, 32'h0);
        rchk(`VCF_FLAG_OFS, 32'h0);
        bus(1'b1, 8'h0C, 32'hFFFF_FFFF);
        rchk(8'h0C, 32'h0);
        bus(1'b1, `VCF_CTRL_OFS, 32'h6);
        rchk(`VCF_CTRL_OFS, 32'h6);
        check({35'h0, hresp}, 36'h0);
        bus(1'b1, `VCF_CTRL_OFS, 32'h0);
    endtask

    task automatic t_packed();
        mark(`VCF_CODE_PACKED);
        ctrl(32'h1);
        ren <= 1'b1;
        for (int b = 0; b < 4; b++) begin
            px(2'h0, 1'b1, 1'b0, 2'h0, 1'b1);
            px(2'h0, 1'b0, 1'b0, 2'h0, 1'b1);
            px(2'h0, 1'b0, 1'b1, 2'(b), 1'b1);
        end
        drain(1'b0);
    endtask

    task automatic t_field();
        q[0].push_back({`VCF_CODE_ODD_END, 32'h0});
        mark(`VCF_CODE_PACKED);
        fodd <= 1'b1;
        wt(12);
        px(2'h0, 1'b0, 1'b0, 2'h0, 1'b1);
        q[0].push_back({`VCF_CODE_EVEN_END, 32'h0});
        mark(`VCF_CODE_PACKED);
        fodd <= 1'b0;
        wt(12);
        fact <= 1'b0;
        px(2'h0, 1'b0, 1'b0, 2'h0, 1'b0);
        wt(1);
        fact <= 1'b1;
        vbi <= 1'b1;
        px(2'h0, 1'b0, 1'b0, 2'h0, 1'b0);
        ctrl(32'h3);
        px(2'h0, 1'b0, 1'b0, 2'h0, 1'b1);
        wt(1);
        vbi <= 1'b0;
        drain(1'b1);
    endtask

    task automatic t_planar();
        logic [1:0] segs[8] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h2, 2'h1, 2'h0, 2'h1};
        rst();
        mark(`VCF_CODE_PLANAR);
        ctrl(32'h5);
        ren <= 1'b1;
        foreach (segs[i]) px(segs[i], 1'b0, 1'b0, 2'h0, 1'b1);
        mark(`VCF_CODE_PACKED);
        ctrl(32'h1);
        for (int i = 0; i < 4; i++) px(2'h2, 1'b0, 1'b0, 2'h0, 1'b1);
        drain(1'b1);
    endtask

    task automatic t_fill();
        rst();
        mark(`VCF_CODE_PACKED);
        ctrl(32'h1);
        for (int j = 1; j <= 33; j++) begin
            repeat (4) px(2'h0, 1'b0, 1'b0, 2'h0, 1'b1);
            if (j >= 30) begin
                wt(2);
                check({30'h0, full, af}, {30'h0, {3{j >= 33}}, {3{j >= 31}}});
            end
        end
        rchk(`VCF_COUNT_OFS, 32'h0022_2244);
        rchk(`VCF_FLAG_OFS, 32'h0000_0077);
        drain(1'b1);
    endtask

    initial begin
        #200000;
        n_fail++;
        test_done();
    end

    initial begin
        rst();
        t_regs();
        t_packed();
        t_field();
        t_planar();
        t_fill();
        test_done();
    end
endmodule
